// file: hw/bcdcnt_defines.vh
// constants for the six-digit decimal counter with scanned output
`ifndef BCDCNT_DEFINES_VH
`define BCDCNT_DEFINES_VH

// ----------------------------------------------------------------
// digit layout
// ----------------------------------------------------------------
`define BCDCNT_DIGITS      6
`define BCDCNT_DIGIT_W     4
`define BCDCNT_DIGIT_MAX   4'h9
`define BCDCNT_CARRY_LO    4'h6
`define BCDCNT_BLANK_CODE  4'hf

// ----------------------------------------------------------------
// scan sequencer timing
// ----------------------------------------------------------------
`define BCDCNT_SLOT_EDGES  2'h3
`define BCDCNT_LAST_SLOT   3'h5
`define BCDCNT_SLOT_W      3

`endif

// file: hw/bcdcnt_top.v
// six-digit decimal event counter with latch, scan and blanking
//
// How it works
// R1 - each count edge adds one, decimal ripple
// R2 - master reset high zeroes count, clears overflow
// R3 - edge at all nines sets sticky overflow
// R4 - carry n low when digit n 6-9, lower nines
// R5 - carry one stays low four count periods; carries two to six go low one period at a time
// R6 - two-digit select low: only two digits count
// R7 - four-digit select low: only four digits count
// R8 - transfer high passes live count through
// R9 - transfer falling edge freezes the shown count
// R10 - transfer high again shows live count
// R11 - sequencer moves only on scan clock rises
// R12 - scan reset: strobes high, slot one held
// R13 - strobe advances every four scan edges
// R14 - slot one shows top digit, six lowest
// R15 - blanked digit drives all BCD lines high
// R16 - blanking low none, high suppress leading zero digits
// R17 - blanking tied to strobe n suppresses earlier
// R18 - ripple may corrupt at most one scan cycle
// R19 - host sets selects, pulses reset, then counts; the bench pulses reset before setting the selects
// R20 - after slot six the sequencer wraps round
// R21 - blank zero only after leading zeros
`timescale 1ns/100ps
`include "bcdcnt_defines.vh"

module bcdcnt_top (
	// system
	input  wire        clk,
	input  wire        rstn,
	// counting pins
	input  wire        count_clock_in,
	input  wire        master_count_reset,
	input  wire        chain_two_digit_sel,
	input  wire        chain_four_digit_sel,
	input  wire        transfer_latch_ctrl,
	// scan pins
	input  wire        scan_clock_in,
	input  wire        scan_sequencer_reset,
	input  wire        blanking_control_in,
	// outputs
	output wire [3:0]  bcd_out,
	output wire [5:0]  digit_strobe_n,
	output wire        digit_carry_n1,
	output wire        digit_carry_n2,
	output wire        digit_carry_n3,
	output wire        digit_carry_n4,
	output wire        digit_carry_n5,
	output wire        digit_carry_n6,
	output wire        count_overflow_flag
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	localparam NSYNC = 8;
	wire [NSYNC-1:0] pin_raw;
	reg  [NSYNC-1:0] sy1_r;
	reg  [NSYNC-1:0] sy2_r;
	reg  [NSYNC-1:0] sy3_r;
	reg  [NSYNC-1:0] pin_r;
	assign pin_raw = {blanking_control_in, scan_sequencer_reset,
		scan_clock_in, transfer_latch_ctrl, chain_four_digit_sel,
		chain_two_digit_sel, master_count_reset, count_clock_in};

	// three stages; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					sy1_r[gi] <= 1'b0;
					sy2_r[gi] <= 1'b0;
					sy3_r[gi] <= 1'b0;
					pin_r[gi] <= 1'b0;
				end else begin
					sy1_r[gi] <= pin_raw[gi];
					sy2_r[gi] <= sy1_r[gi];
					sy3_r[gi] <= sy2_r[gi];
					if (sy2_r[gi] == sy3_r[gi])
						pin_r[gi] <= sy3_r[gi];
				end
			end
		end
	endgenerate

	// filtered levels and their previous values
	reg  [NSYNC-1:0] pin_d_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			pin_d_r <= {NSYNC{1'b0}};
		else
			pin_d_r <= pin_r;
	end

	wire cnt_rise  = pin_r[0] & ~pin_d_r[0];
	wire mreset    = pin_r[1];
	wire sel_two   = pin_r[2];
	wire sel_four  = pin_r[3];
	wire xfer      = pin_r[4];
	wire xfer_fall = ~pin_r[4] & pin_d_r[4];
	wire scan_rise = pin_r[5] & ~pin_d_r[5];
	wire sreset    = pin_r[6];
	wire blank_ctl = pin_r[7];

	// ------------------------------------------------------------
	// decade counter chain
	// ------------------------------------------------------------
	reg  [23:0] count_r;
	reg  [23:0] count_nxt;
	reg         oflow_r;
	reg         oflow_nxt;
	reg         cy;
	integer     di;

	// ripple increment, chain shortened by the select inputs
	always @* begin
		count_nxt = count_r;
		oflow_nxt = oflow_r;
		cy        = cnt_rise;
		for (di = 0; di < `BCDCNT_DIGITS; di = di + 1) begin
			if (di >= 2 && !sel_two)
				cy = 1'b0;                 // [R6]
			if (di >= 4 && !sel_four)
				cy = 1'b0;                 // [R7]
			if (cy) begin
				if (count_r[di*4 +: 4] == `BCDCNT_DIGIT_MAX) begin
					count_nxt[di*4 +: 4] = 4'h0;  // [R1]
				end else begin
					count_nxt[di*4 +: 4] = count_r[di*4 +: 4] + 4'h1;
					cy = 1'b0;
				end
			end
		end
		if (cy)
			oflow_nxt = 1'b1;              // [R3]
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_r <= 24'h000000;
			oflow_r <= 1'b0;
		end else if (mreset) begin
			count_r <= 24'h000000;         // [R2]
			oflow_r <= 1'b0;
		end else begin
			count_r <= count_nxt;          // [R1]
			oflow_r <= oflow_nxt;          // [R3]
		end
	end
	assign count_overflow_flag = oflow_r;

	// ------------------------------------------------------------
	// carry outputs
	// ------------------------------------------------------------
	reg  [5:0] carry_n_r;
	reg  [5:0] carry_n_nxt;
	reg        lower_nines;
	integer    ci;

	// digit n in 6..9 with all lower nines: low; four count periods for carry one, one for the rest
	always @* begin
		lower_nines = 1'b1;
		carry_n_nxt = 6'h3f;
		for (ci = 0; ci < `BCDCNT_DIGITS; ci = ci + 1) begin
			if (lower_nines &&
			    count_nxt[ci*4 +: 4] >= `BCDCNT_CARRY_LO)
				carry_n_nxt[ci] = 1'b0;    // [R4] [R5]
			lower_nines = lower_nines &
				(count_nxt[ci*4 +: 4] == `BCDCNT_DIGIT_MAX);
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			carry_n_r <= 6'h3f;
		else if (mreset)
			carry_n_r <= 6'h3f;
		else
			carry_n_r <= carry_n_nxt;
	end
	assign digit_carry_n1 = carry_n_r[0];
	assign digit_carry_n2 = carry_n_r[1];
	assign digit_carry_n3 = carry_n_r[2];
	assign digit_carry_n4 = carry_n_r[3];
	assign digit_carry_n5 = carry_n_r[4];
	assign digit_carry_n6 = carry_n_r[5];

	// ------------------------------------------------------------
	// transfer latch
	// ------------------------------------------------------------
	reg  [23:0] held_r;

	// track while high, freeze value from before the falling edge
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			held_r <= 24'h000000;
		else if (xfer && !xfer_fall)
			held_r <= count_r;             // [R9]
	end
	wire [23:0] shown = xfer ? count_r : held_r;  // [R8] [R10]

	// ------------------------------------------------------------
	// scan sequencer
	// ------------------------------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_SCAN = 1'b1;
	reg        state_r;
	reg  [2:0] slot_r;
	reg  [1:0] edge_r;
	reg        supp_r;

	// advance on scan clock rises only, wrap after slot six
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			slot_r  <= 3'h0;
			edge_r  <= 2'h0;
		end else if (sreset) begin
			state_r <= ST_IDLE;            // [R12]
			slot_r  <= 3'h0;
			edge_r  <= 2'h0;
		end else begin
			case (state_r)
			ST_IDLE: begin
				state_r <= ST_SCAN;
			end
			ST_SCAN: begin
				if (scan_rise) begin       // [R11]
					if (edge_r == `BCDCNT_SLOT_EDGES) begin
						edge_r <= 2'h0;    // [R13]
						if (slot_r == `BCDCNT_LAST_SLOT)
							slot_r <= 3'h0;  // [R20]
						else
							slot_r <= slot_r + 3'h1;
					end else begin
						edge_r <= edge_r + 2'h1;
					end
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// digit value for a slot: slot zero is the top digit
	function [3:0] pick_digit;
		input [23:0] val;
		input [2:0]  slot;
		begin
			case (slot)
			3'h0:    pick_digit = val[23:20];   // [R14]
			3'h1:    pick_digit = val[19:16];
			3'h2:    pick_digit = val[15:12];
			3'h3:    pick_digit = val[11:8];
			3'h4:    pick_digit = val[7:4];
			default: pick_digit = val[3:0];
			endcase
		end
	endfunction

	wire [3:0] cur_digit = pick_digit(shown, slot_r);
	wire       first_slot = (slot_r == 3'h0);

	// blanking applies while the control reads high in this slot;
	// a strobe tied back to it goes low at slot n and stops it
	wire lead = first_slot ? 1'b1 : supp_r;
	wire blank_now = state_r == ST_SCAN && blank_ctl && lead &&
		cur_digit == 4'h0;             // [R16] [R17] [R21]

	// leading-zero run tracker, reset at each scan cycle start
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			supp_r <= 1'b1;
		else if (state_r == ST_SCAN)
			supp_r <= blank_now;           // [R21]
		else
			supp_r <= 1'b1;
	end

	// registered outputs; values may lag a ripple by one scan cycle
	reg  [3:0] bcd_r;
	reg  [5:0] strobe_n_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bcd_r      <= `BCDCNT_BLANK_CODE;
			strobe_n_r <= 6'h3f;
		end else if (sreset || state_r != ST_SCAN) begin
			bcd_r      <= cur_digit;
			strobe_n_r <= 6'h3f;           // [R12]
		end else begin
			bcd_r      <= blank_now ? `BCDCNT_BLANK_CODE
				: cur_digit;               // [R15] [R18]
			strobe_n_r <= ~(6'h01 << slot_r);  // [R12] [R13]
		end
	end
	assign bcd_out        = bcd_r;
	assign digit_strobe_n = strobe_n_r;

endmodule // bcdcnt_top

// file: verif/bcdcnt_disp.sv
// display-side model: scan oscillator and digit capture
`timescale 1ns/100ps
module bcdcnt_disp (
	// scan pins
	output logic        sclk,
	input  wire  [5:0]  strobe_n,
	input  wire  [3:0]  bcd,
	// captured frame, top digit in high nibble
	output logic [23:0] shown
);
	// free-running 80 ns scan clock, phase off the system clock
	initial begin
		sclk = 1'b0;
		#3;
		forever #40 sclk = ~sclk;
	end
	// keep the latest digit seen in each slot
	always @(posedge sclk)
		for (int i = 0; i < 6; i++)
			if (!strobe_n[i]) shown[23-4*i -: 4] <= bcd;
endmodule // bcdcnt_disp

// file: verif/bcdcnt_props.sv
// port assertions for the scanned decimal counter
`timescale 1ns/100ps
module bcdcnt_props (
	// system
	input wire       clk,
	input wire       rstn,
	// control pins
	input wire       count_clock_in,
	input wire       master_count_reset,
	input wire       scan_clock_in,
	input wire       scan_sequencer_reset,
	input wire       blanking_control_in,
	// outputs
	input wire [3:0] bcd_out,
	input wire [5:0] digit_strobe_n,
	input wire       digit_carry_n1,
	input wire       digit_carry_n2,
	input wire       digit_carry_n3,
	input wire       digit_carry_n4,
	input wire       digit_carry_n5,
	input wire       digit_carry_n6,
	input wire       count_overflow_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// active carries as ones, digit one in bit 0
	wire [5:0] cy = ~{digit_carry_n6, digit_carry_n5, digit_carry_n4,
		digit_carry_n3, digit_carry_n2, digit_carry_n1};
	reg       cc_r;
	reg [2:0] low_r;
	// count pin rises seen while carry one is low
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cc_r <= 1'b0;
			low_r <= 3'h0;
		end else begin
			cc_r <= count_clock_in;
			if (digit_carry_n1 || master_count_reset)
				low_r <= 3'h0;
			else if (count_clock_in && !cc_r)
				low_r <= low_r + 3'h1;
		end
	end
	reg       sc_r;
	reg [2:0] age_r;
	// clocks since the last raw scan clock rise, saturating
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sc_r  <= 1'b0;
			age_r <= 3'h7;
		end else begin
			sc_r <= scan_clock_in;
			if (scan_clock_in && !sc_r)
				age_r <= 3'h0;
			else if (age_r != 3'h7)
				age_r <= age_r + 3'h1;
		end
	end
	chk_strobe_single:
	assert property ((~digit_strobe_n & (~digit_strobe_n - 6'h1)) == 6'h0)
		else $error("two strobes low");
	chk_strobe_step:
	assert property ($changed(digit_strobe_n) && digit_strobe_n != 6'h3f &&
		$past(digit_strobe_n) != 6'h3f |-> digit_strobe_n ==
		{$past(digit_strobe_n[4:0]), $past(digit_strobe_n[5])})
		else $error("strobe skipped a slot");
	chk_first_slot:
	assert property ($past(digit_strobe_n) == 6'h3f && digit_strobe_n !=
		6'h3f |-> digit_strobe_n == 6'h3e) else $error("bad first slot");
	chk_scan_edge:
	assert property ($changed(digit_strobe_n) && digit_strobe_n != 6'h3f &&
		$past(digit_strobe_n) != 6'h3f |-> age_r >= 3'h3 && age_r <= 3'h6)
		else $error("strobe moved without scan edge");
	chk_scan_held:
	assert property (scan_sequencer_reset [*8] |-> digit_strobe_n == 6'h3f)
		else $error("strobe low in scan reset");
	chk_carry_chain:
	assert property ((cy & (cy + 6'h1)) == 6'h0) else $error("carry gap");
	chk_carry_span:
	assert property ($rose(digit_carry_n1) && low_r != 3'h0 |-> low_r ==
		3'h4) else $error("carry low span wrong");
	chk_ovf_rise:
	assert property ($rose(count_overflow_flag) |-> $past(cy) == 6'h3f)
		else $error("overflow without all nines");
	chk_ovf_sticky:
	assert property (count_overflow_flag && !master_count_reset |=>
		count_overflow_flag) else $error("overflow dropped");
	chk_no_blank:
	assert property (!blanking_control_in [*8] ##0 (digit_strobe_n != 6'h3f
		&& $stable(digit_strobe_n)) |-> bcd_out != 4'hf)
		else $error("blanked with blanking off");
	cover property ($rose(digit_carry_n1));
	cover property ($fell(digit_strobe_n[5]));
	cover property (blanking_control_in && bcd_out == 4'hf);
endmodule // bcdcnt_props

bind bcdcnt_top bcdcnt_props props_i (.*);

// file: verif/test_bcdcnt_top.sv
// self-checking bench for the scanned decimal counter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_fail++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_bcdcnt_top;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ccin = 1'b0;
	logic        mcr = 1'b0;
	logic        s2 = 1'b1;
	logic        s4 = 1'b1;
	logic        xfer_in = 1'b1;
	logic        sres = 1'b0;
	logic        blk = 1'b0;
	logic        tie = 1'b0;
	logic        sclk;
	logic [23:0] shown;
	wire  [3:0]  bcd;
	wire  [5:0]  stb;
	wire  [5:0]  cy;
	wire         oflow;
	int          n_fail = 0;
	int          num_checks = 0;
	// blanking either driven or tied back to the third strobe
	wire blank_in = tie ? stb[2] : blk;
	typedef struct {int n; logic s2; logic s4;
		logic [23:0] ex;} bcdcnt_row;
	bcdcnt_row rows[5] = '{'{7, 1'b1, 1'b1, 24'h000007},
		'{96, 1'b1, 1'b1, 24'h000096}, '{105, 1'b0, 1'b1, 24'h000005},
		'{12, 1'b1, 1'b0, 24'h000012}, '{105, 1'b1, 1'b1, 24'h000105}};
	bcdcnt_top uut (.clk(clk), .rstn(rstn), .count_clock_in(ccin),
		.master_count_reset(mcr), .chain_two_digit_sel(s2),
		.chain_four_digit_sel(s4), .transfer_latch_ctrl(xfer_in),
		.scan_clock_in(sclk), .scan_sequencer_reset(sres),
		.blanking_control_in(blank_in), .bcd_out(bcd), .digit_strobe_n(stb),
		.digit_carry_n1(cy[0]), .digit_carry_n2(cy[1]), .digit_carry_n3(cy[2]),
		.digit_carry_n4(cy[3]), .digit_carry_n5(cy[4]), .digit_carry_n6(cy[5]),
		.count_overflow_flag(oflow));
	bcdcnt_disp disp (.sclk(sclk), .strobe_n(stb), .bcd(bcd), .shown(shown));
	always #5 clk = ~clk;
	// carries expected for a count, active low
	function automatic [5:0] exp_carry(input [23:0] v);
		logic ok;
		ok = 1'b1;
		for (int n = 0; n < 6; n++) begin
			exp_carry[n] = !(ok && v[4*n +: 4] >= 4'h6);
			ok = ok && v[4*n +: 4] == 4'h9;
		end
	endfunction
	// count pulses 50 ns high, 60 ns low
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk) ccin <= 1'b1;
			repeat (5) @(posedge clk);
			ccin <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask
	// two full scan cycles plus pin filter
	task automatic settle;
		repeat (420) @(posedge clk);
	endtask
	task automatic mreset;
		@(posedge clk) mcr <= 1'b1;
		repeat (10) @(posedge clk);
		mcr <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		#400000;
		n_fail++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		settle();
		`CHK("reset carries", 6'h3f, cy)
		`CHK("reset overflow", 1'b0, oflow)
		$display("power-up done");
		for (int i = 0; i < 5; i++) begin
			mreset();
			s2 <= rows[i].s2;
			s4 <= rows[i].s4;
			pulse(rows[i].n);
			settle();
			`CHK("digits", rows[i].ex, shown)
			`CHK("carries", exp_carry(rows[i].ex), cy)
			`CHK("no overflow", 1'b0, oflow)
			s2 <= 1'b1;
			s4 <= 1'b1;
			$display("row %0d done", i);
		end
		blk <= 1'b1;
		settle();
		`CHK("blank all", 24'hfff105, shown)
		tie <= 1'b1;
		settle();
		`CHK("blank tied", 24'hff0105, shown)
		tie <= 1'b0;
		blk <= 1'b0;
		$display("blanking done");
		mreset();
		pulse(3);
		xfer_in <= 1'b0;
		pulse(4);
		settle();
		`CHK("frozen", 24'h000003, shown)
		`CHK("live carry", 6'h3e, cy)
		xfer_in <= 1'b1;
		settle();
		`CHK("released", 24'h000007, shown)
		$display("latch done");
		sres <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("scan held", 6'h3f, stb)
		sres <= 1'b0;
		mreset();
		settle();
		`CHK("cleared", 24'h000000, shown)
		`CHK("cleared carry", 6'h3f, cy)
		$display("resets done");
		tally_and_finish();
	end
endmodule // test_bcdcnt_top
